/* File: hdl/dmast_cfg.svh */
// phase timing constants for the stream item sequencer
// assumes inclusion by bare name from the design files
`ifndef DMAST_CFG_SVH
`define DMAST_CFG_SVH
`define DMAST_NSTREAM        8
`define DMAST_SEL_W          3
`define DMAST_CNT_W          8
`define DMAST_PORT_ARB_CYC   8'h01
`define DMAST_ADDR_CYC       8'h01
`define DMAST_MATRIX_ARB_CYC 8'h01
`define DMAST_AHB_XFER_CYC   8'h01
`define DMAST_APB_XFER_CYC   8'h02
`define DMAST_BUS_SYNC_CYC   8'h01
`define DMAST_SRAM_CYC       8'h01
`define DMAST_APB_RATIO      8'h01
`define DMAST_FIFO_THR       8'h04
`define DMAST_FIFO_W         4
`endif

/* File: hdl/dmast_pkg.sv */
// types for the stream item sequencer
// assumes dmast_cfg.svh sits in the include path
`include "dmast_cfg.svh"
package dmast_pkg;
    // peripheral path: through matrix to ahb/apb, or direct apb
    typedef enum logic [1:0] {
        DMAST_PATH_AHB    = 2'h0,
        DMAST_PATH_APB    = 2'h1,
        DMAST_PATH_DIRECT = 2'h2
    } dmast_path_t;
    typedef enum logic [2:0] {
        DMAST_PH_IDLE  = 3'h0,
        DMAST_PH_ARB   = 3'h1,
        DMAST_PH_ADDR  = 3'h3,
        DMAST_PH_MARB  = 3'h2,
        DMAST_PH_XFER  = 3'h6,
        DMAST_PH_SYNC  = 3'h7
    } dmast_phase_t;
endpackage

/* File: hdl/dmast_port_seq.sv */
// one master port phase sequencer: arbitrate, address, matrix, data, sync
// assumes grant/ready come from bus matrix or bridge, synchronous to mclk
`timescale 1ns/100ps
`default_nettype none
`include "dmast_cfg.svh"
module dmast_port_seq (
    input  wire logic                    mclk,
    input  wire logic                    rst_n,
    input  wire logic                    start,
    input  wire logic [`DMAST_CNT_W-1:0] marb_cyc,
    input  wire logic [`DMAST_CNT_W-1:0] xfer_cyc,
    input  wire logic [`DMAST_CNT_W-1:0] sync_cyc,
    input  wire logic                    bus_grant,
    input  wire logic                    bus_ready,
    output dmast_pkg::dmast_phase_t      phase,
    output logic                         last_data,
    output logic                         done,
    output logic [`DMAST_CNT_W-1:0]      elapsed
);
    import dmast_pkg::*;
    dmast_phase_t phase_r;
    dmast_phase_t phase_nxt;
    logic [`DMAST_CNT_W-1:0] cnt_r;
    logic [`DMAST_CNT_W-1:0] el_r;
    logic                    step;
    logic                    fin;

    // zero-cost matrix and sync phases are skipped outright
    always_comb begin
        step = (cnt_r <= 8'h01);
        phase_nxt = phase_r;
        case (phase_r)
            DMAST_PH_IDLE: if (start) phase_nxt = DMAST_PH_ARB;
            DMAST_PH_ARB:  if (step) phase_nxt = DMAST_PH_ADDR;
            DMAST_PH_ADDR: begin
                if (step) begin
                    phase_nxt = (marb_cyc != 8'h00) ? DMAST_PH_MARB
                                                    : DMAST_PH_XFER;
                end
            end
            // wait for matrix or bridge grant under contention
            DMAST_PH_MARB: begin
                if (step && bus_grant) phase_nxt = DMAST_PH_XFER;
            end
            // ready low stretches the data phase: wait states
            DMAST_PH_XFER: begin
                if (step && bus_ready) begin
                    phase_nxt = (sync_cyc != 8'h00) ? DMAST_PH_SYNC
                                                    : DMAST_PH_IDLE;
                end
            end
            DMAST_PH_SYNC: if (step) phase_nxt = DMAST_PH_IDLE;
            default:       phase_nxt = DMAST_PH_IDLE;
        endcase
        // a start in the closing cycle chains straight into arbitration,
        // otherwise the grant taken by the top would be lost
        fin = (phase_r != DMAST_PH_IDLE) && (phase_nxt == DMAST_PH_IDLE);
        if (fin && start) phase_nxt = DMAST_PH_ARB;
    end

    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            phase_r <= DMAST_PH_IDLE;
        end else begin
            phase_r <= phase_nxt;
        end
    end

    // phase length loaded on entry, counted down, held while stalled
    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            cnt_r <= 8'h00;
        end else if (phase_nxt != phase_r) begin
            case (phase_nxt)
                DMAST_PH_ARB:  cnt_r <= `DMAST_PORT_ARB_CYC;
                DMAST_PH_ADDR: cnt_r <= `DMAST_ADDR_CYC;
                DMAST_PH_MARB: cnt_r <= marb_cyc;
                DMAST_PH_XFER: cnt_r <= xfer_cyc;
                DMAST_PH_SYNC: cnt_r <= sync_cyc;
                default:       cnt_r <= 8'h00;
            endcase
        end else if (cnt_r > 8'h01) begin
            cnt_r <= cnt_r - 8'h01;
        end
    end

    // cycles spent: sum of all phases plus stalls
    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            el_r <= 8'h00;
        end else if ((phase_r == DMAST_PH_IDLE) || fin) begin
            el_r <= 8'h00;
        end else begin
            el_r <= el_r + 8'h01;
        end
    end

    always_comb begin
        phase     = phase_r;
        elapsed   = el_r;
        last_data = (phase_r == DMAST_PH_XFER) && step && bus_ready;
        done      = fin;
    end
endmodule
`default_nettype wire

/* File: hdl/dmast_top.sv */
// stream item timing sequencer: peripheral port plus memory port
// assumes grant/ready/requests synchronous to mclk, no software registers
//
// Notes on behaviour
// - each p2m item uses peripheral then memory access
// - fifo mode writes at threshold; direct immediately
// - peripheral read: arbitrate, address, then data
// - m2p prefetches memory into fifo before request
// - m2p request: arbitrate, address, write fifo data
// - port arbitration and address one cycle each
// - peripheral time sums five phases, absent zero
// - matrix arbitration one cycle, none direct
// - ahb one cycle; apb two plus sync
// - burst data time scales with beat count
// - memory time four phases, one cycle each
// - repeated sram access skips matrix arbitration
// - item time is peripheral plus memory time
// - hold transfer until matrix grants access
// - bridge contention delays transfer before proceeding
// - eight streams arbitrated by priority per port
// - rearbitrate in the closing cycle, masking served stream
`timescale 1ns/100ps
`default_nettype none
`include "dmast_cfg.svh"
module dmast_top #(
    parameter logic [`DMAST_CNT_W-1:0] MATRIX_ARB_CYC = `DMAST_MATRIX_ARB_CYC,
    parameter logic [`DMAST_CNT_W-1:0] APB_RATIO      = `DMAST_APB_RATIO
) (
    input  wire logic                     mclk,
    input  wire logic                     rst_n,
    input  wire logic [`DMAST_NSTREAM-1:0] periph_req,
    input  wire logic [`DMAST_NSTREAM-1:0] stream_m2p,
    input  wire dmast_pkg::dmast_path_t   periph_path,
    input  wire logic [`DMAST_CNT_W-1:0]  burst_beats,
    input  wire logic                     fifo_mode,
    input  wire logic [`DMAST_FIFO_W-1:0] fifo_thr,
    input  wire logic                     periph_grant,
    input  wire logic                     periph_ready,
    input  wire logic                     mem_grant,
    input  wire logic                     mem_ready,
    input  wire logic                     sram_other_master,
    output logic                          periph_busy_r,
    output logic [`DMAST_SEL_W-1:0]       periph_stream_r,
    output logic                          mem_busy_r,
    output logic                          mem_write_r,
    output logic [`DMAST_SEL_W-1:0]       mem_stream_r,
    output logic                          item_done_r,
    output logic [`DMAST_CNT_W-1:0]       periph_port_total_time,
    output logic [`DMAST_CNT_W-1:0]       mem_port_total_time,
    output logic [`DMAST_CNT_W-1:0]       item_total_time
);
    import dmast_pkg::*;

    // ****************************************************************
    // per-stream state
    // ****************************************************************
    logic [`DMAST_FIFO_W-1:0]  fill_r [`DMAST_NSTREAM];
    logic [`DMAST_NSTREAM-1:0] mem_need;
    logic [`DMAST_NSTREAM-1:0] per_need;
    logic [`DMAST_NSTREAM-1:0] per_mask;
    logic [`DMAST_NSTREAM-1:0] mem_mask;
    logic                      p_start;
    logic                      m_start;
    logic                      p_done;
    logic                      m_done;
    logic [`DMAST_CNT_W-1:0]   p_el;
    logic [`DMAST_CNT_W-1:0]   m_el;
    logic [`DMAST_CNT_W-1:0]   p_marb;
    logic [`DMAST_CNT_W-1:0]   p_xfer;
    logic [`DMAST_CNT_W-1:0]   p_sync;
    logic [`DMAST_CNT_W-1:0]   m_marb;
    logic [`DMAST_CNT_W-1:0]   m_xfer;
    logic [`DMAST_SEL_W-1:0]   p_pick;
    logic [`DMAST_SEL_W-1:0]   m_pick;
    logic                      p_any;
    logic                      m_any;
    logic                      sram_owned_r;
    logic [`DMAST_CNT_W-1:0]   p_time_r;

    genvar gi;
    generate
        for (gi = 0; gi < `DMAST_NSTREAM; gi++) begin : g_str
            // m2p: memory read while fifo empty; p2m: drain when due
            always_comb begin
                if (stream_m2p[gi]) begin
                    mem_need[gi] = (fill_r[gi] == '0);
                    per_need[gi] = periph_req[gi] &&
                                   (fill_r[gi] != '0);
                end else begin
                    mem_need[gi] = fifo_mode ?
                                   (fill_r[gi] >= fifo_thr) &&
                                   (fifo_thr != '0)
                                 : (fill_r[gi] != '0);
                    per_need[gi] = periph_req[gi];
                end
            end
            always_ff @(posedge mclk or negedge rst_n) begin
                if (!rst_n) begin
                    fill_r[gi] <= '0;
                end else begin
                    case ({p_done && (periph_stream_r == gi),
                           m_done && (mem_stream_r == gi)})
                        2'b10: fill_r[gi] <= stream_m2p[gi] ?
                                   fill_r[gi] - 4'h1 : fill_r[gi] + 4'h1;
                        2'b01: fill_r[gi] <= stream_m2p[gi] ?
                                   fill_r[gi] + 4'h1 : '0;
                        default: fill_r[gi] <= fill_r[gi];
                    endcase
                end
            end
        end
    endgenerate

    // ****************************************************************
    // priority arbiters, stream 0 highest
    // ****************************************************************
    always_comb begin
        per_mask = per_need;
        mem_mask = mem_need;
        // served stream masked while its port is busy
        if (periph_busy_r) per_mask[periph_stream_r] = 1'b0;
        if (mem_busy_r) mem_mask[mem_stream_r] = 1'b0;
        p_any  = |per_mask;
        m_any  = |mem_mask;
        p_pick = '0;
        m_pick = '0;
        for (int i = `DMAST_NSTREAM - 1; i >= 0; i--) begin
            if (per_mask[i]) p_pick = i[`DMAST_SEL_W-1:0];
            if (mem_mask[i]) m_pick = i[`DMAST_SEL_W-1:0];
        end
        // next grant picked in the closing cycle of the current one, so
        // the sequencer chains into arbitration with no idle gap
        p_start = p_any && (!periph_busy_r || p_done);
        m_start = m_any && (!mem_busy_r || m_done);
    end

    // ****************************************************************
    // phase costs per path
    // ****************************************************************
    always_comb begin
        p_marb = MATRIX_ARB_CYC;
        if (periph_path == DMAST_PATH_DIRECT) p_marb = 8'h00;
        p_sync = `DMAST_BUS_SYNC_CYC;
        if (periph_path == DMAST_PATH_AHB) p_sync = 8'h00;
        if (periph_path == DMAST_PATH_AHB) begin
            // one beat per ahb cycle, incr4 gives four
            p_xfer = (burst_beats == 8'h00) ? `DMAST_AHB_XFER_CYC
                                            : burst_beats;
        end else begin
            p_xfer = 8'(`DMAST_APB_XFER_CYC * APB_RATIO);
        end
        // no other master since last access: skip matrix cost
        m_marb = sram_owned_r ? 8'h00 : MATRIX_ARB_CYC;
        m_xfer = `DMAST_SRAM_CYC;
    end

    // bridge contention seen as periph_grant low in matrix phase
    dmast_port_seq u_pseq (
        .mclk      (mclk),
        .rst_n     (rst_n),
        .start     (p_start),
        .marb_cyc  (p_marb),
        .xfer_cyc  (p_xfer),
        .sync_cyc  (p_sync),
        .bus_grant (periph_grant),
        .bus_ready (periph_ready),
        .phase     (),
        .last_data (),
        .done      (p_done),
        .elapsed   (p_el)
    );

    dmast_port_seq u_mseq (
        .mclk      (mclk),
        .rst_n     (rst_n),
        .start     (m_start),
        .marb_cyc  (m_marb),
        .xfer_cyc  (m_xfer),
        .sync_cyc  (8'h00),
        .bus_grant (mem_grant),
        .bus_ready (mem_ready),
        .phase     (),
        .last_data (),
        .done      (m_done),
        .elapsed   (m_el)
    );

    // ****************************************************************
    // port ownership and timing results
    // ****************************************************************
    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            periph_busy_r   <= 1'b0;
            periph_stream_r <= '0;
        end else if (p_start) begin
            periph_busy_r   <= 1'b1;
            periph_stream_r <= p_pick;
        end else if (p_done) begin
            periph_busy_r   <= 1'b0;
        end
    end

    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            mem_busy_r   <= 1'b0;
            mem_write_r  <= 1'b0;
            mem_stream_r <= '0;
        end else if (m_start) begin
            mem_busy_r   <= 1'b1;
            mem_write_r  <= !stream_m2p[m_pick];
            mem_stream_r <= m_pick;
        end else if (m_done) begin
            mem_busy_r   <= 1'b0;
        end
    end

    // a foreign master in between forces a fresh matrix arbitration
    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            sram_owned_r <= 1'b0;
        end else if (sram_other_master) begin
            sram_owned_r <= 1'b0;
        end else if (m_done) begin
            sram_owned_r <= 1'b1;
        end
    end

    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            periph_port_total_time <= '0;
            mem_port_total_time    <= '0;
            p_time_r               <= '0;
            item_total_time        <= '0;
            item_done_r            <= 1'b0;
        end else begin
            item_done_r <= 1'b0;
            if (p_done) begin
                periph_port_total_time <= p_el + 8'h01;
                p_time_r               <= p_el + 8'h01;
            end
            if (m_done) begin
                mem_port_total_time <= m_el + 8'h01;
                item_total_time     <= p_time_r + m_el + 8'h01;
                item_done_r         <= 1'b1;
            end
        end
    end
endmodule
`default_nettype wire

/* File: verification/dmast_top_props.sv */
// checker for the stream item sequencer, bound to dmast_top
// assumes single mclk domain and async active-low rst_n
`timescale 1ns/100ps
`default_nettype none
`include "dmast_cfg.svh"
module dmast_top_props (
    input wire logic                      mclk,
    input wire logic                      rst_n,
    input wire logic [`DMAST_NSTREAM-1:0] periph_req,
    input wire logic [`DMAST_NSTREAM-1:0] stream_m2p,
    input wire logic                      fifo_mode,
    input wire logic                      periph_grant,
    input wire logic                      periph_busy_r,
    input wire logic [`DMAST_SEL_W-1:0]   periph_stream_r,
    input wire logic                      mem_busy_r,
    input wire logic                      mem_write_r,
    input wire logic [`DMAST_SEL_W-1:0]   mem_stream_r,
    input wire logic                      item_done_r,
    input wire logic [`DMAST_CNT_W-1:0]   periph_port_total_time,
    input wire logic [`DMAST_CNT_W-1:0]   mem_port_total_time,
    input wire logic [`DMAST_CNT_W-1:0]   item_total_time
);
    default clocking cb @(posedge mclk); endclocking
    default disable iff (!rst_n);
    // ****************************************
    // assertions
    // ****************************************
    a_req_taken: assert property (
        (|(periph_req & ~stream_m2p)) && !periph_busy_r |=> periph_busy_r)
        else $error("peripheral request not taken");
    a_busy_min_len: assert property (
        $rose(periph_busy_r) |-> periph_busy_r [*3])
        else $error("peripheral access shorter than three phases");
    a_periph_min_time: assert property (
        $changed(periph_port_total_time) |-> periph_port_total_time >= 8'h04)
        else $error("peripheral time below phase floor");
    a_mem_time_val: assert property (
        $changed(mem_port_total_time) |->
            mem_port_total_time inside {8'h03, 8'h04})
        else $error("memory time not three or four");
    a_item_sum_ok: assert property (
        item_done_r |-> item_total_time ==
            8'(periph_port_total_time + mem_port_total_time))
        else $error("item time not the sum of port times");
    a_done_pulse_one: assert property (item_done_r |=> !item_done_r)
        else $error("item done longer than one cycle");
    a_done_cause_mem: assert property (
        item_done_r |-> $past(mem_busy_r) || $past(mem_busy_r, 2))
        else $error("item done without memory access");
    a_write_dir_ok: assert property (
        mem_busy_r && mem_write_r |-> !stream_m2p[mem_stream_r])
        else $error("memory write on a memory-to-peripheral stream");
    a_direct_mem_follow: assert property (
        $fell(periph_busy_r) && !fifo_mode && !stream_m2p[periph_stream_r]
            |-> ##[0:3] (mem_busy_r && mem_write_r))
        else $error("direct mode memory write not launched");
    // ****************************************
    // covers
    // ****************************************
    c_item_done: cover property (item_done_r);
    c_prefetch: cover property (mem_busy_r && !mem_write_r);
    c_grant_wait: cover property (periph_busy_r && !periph_grant);
    c_fifo_item: cover property ($rose(periph_busy_r) && fifo_mode);
endmodule
bind dmast_top dmast_top_props i_props (
    .mclk(mclk), .rst_n(rst_n), .periph_req(periph_req),
    .stream_m2p(stream_m2p), .fifo_mode(fifo_mode),
    .periph_grant(periph_grant), .periph_busy_r(periph_busy_r),
    .periph_stream_r(periph_stream_r), .mem_busy_r(mem_busy_r),
    .mem_write_r(mem_write_r), .mem_stream_r(mem_stream_r),
    .item_done_r(item_done_r),
    .periph_port_total_time(periph_port_total_time),
    .mem_port_total_time(mem_port_total_time),
    .item_total_time(item_total_time));
`default_nettype wire

/* File: verification/dmast_bus_partner.sv */
// bus matrix, bridge and sram model facing the sequencer's two ports
// assumes mclk domain; slow selects contention and wait states
`timescale 1ns/100ps
`default_nettype none
module dmast_bus_partner (
    input  wire logic mclk,
    input  wire logic rst_n,
    input  wire logic slow,
    input  wire logic other_req,
    output logic      periph_grant,
    output logic      periph_ready,
    output logic      mem_grant,
    output logic      mem_ready,
    output logic      sram_other_master
);
    logic [1:0] slot_r;
    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            slot_r <= 2'h0;
        end else begin
            slot_r <= slot_r + 2'h1;
        end
    end
    // one slot in four lost to the other master: wait bounded
    assign periph_grant = !slow || slot_r != 2'h1;
    assign periph_ready = !slow || slot_r[0];
    assign mem_grant = 1'b1;
    assign mem_ready = 1'b1;
    assign sram_other_master = other_req;
endmodule
`default_nettype wire

/* File: verification/tb_top.sv */
// self-checking bench for dmast_top with a bus partner model
// assumes default parameters: matrix arbitration 1, apb ratio 1
`timescale 1ns/100ps
`default_nettype none
`include "dmast_cfg.svh"
`define CHK(a, b) begin total_checks++; if ((a) !== (b)) begin fails++; \
    $display("MISMATCH t=%0t got=%h exp=%h", $time, a, b); end end
module tb_top;
    import dmast_pkg::*;
    logic mclk = 1'b0, rst_n = 1'b0, fifo_mode = 1'b0, slow = 1'b0;
    logic other_req = 1'b0;
    logic [7:0] periph_req = 8'h00, stream_m2p = 8'h00, burst_beats = 8'h01;
    logic [3:0] fifo_thr = 4'h2;
    dmast_path_t periph_path = DMAST_PATH_AHB;
    logic pg, pr, mg, mr, som, pbusy, mbusy, mwr, done;
    logic [2:0] pstr, mstr;
    logic [7:0] tsp, tsm, ts;
    int fails = 0, total_checks = 0, cycles = 0, n;
    int exp_q[$];
    always #25 mclk = ~mclk;
    dmast_bus_partner i_bus (.mclk(mclk), .rst_n(rst_n), .slow(slow),
        .other_req(other_req), .periph_grant(pg), .periph_ready(pr),
        .mem_grant(mg), .mem_ready(mr), .sram_other_master(som));
    dmast_top i_dut (.mclk(mclk), .rst_n(rst_n), .periph_req(periph_req),
        .stream_m2p(stream_m2p), .periph_path(periph_path),
        .burst_beats(burst_beats), .fifo_mode(fifo_mode),
        .fifo_thr(fifo_thr), .periph_grant(pg), .periph_ready(pr),
        .mem_grant(mg), .mem_ready(mr), .sram_other_master(som),
        .periph_busy_r(pbusy), .periph_stream_r(pstr), .mem_busy_r(mbusy),
        .mem_write_r(mwr), .mem_stream_r(mstr), .item_done_r(done),
        .periph_port_total_time(tsp), .mem_port_total_time(tsm),
        .item_total_time(ts));
    // ****************************************
    // reference model and helpers
    // ****************************************
    function automatic int exp_sp(int path, int beats);
        int x;
        x = (beats == 0) ? 1 : beats;
        if (path == 0) return 3 + x;
        if (path == 1) return 6;
        return 5;
    endfunction
    task automatic end_of_test();
        $display("checks=%0d fails=%0d", total_checks, fails);
        if (fails == 0 && total_checks > 0) $display("All checks passed");
        else $display("Checks failed");
        $finish;
    endtask
    always @(posedge mclk) begin
        cycles++;
        if (cycles == 6000) begin
            fails++;
            end_of_test();
        end
    end
    // bounded wait, sampled on the falling edge where outputs are settled
    task automatic wait_for(ref logic s, input logic v, output logic ok);
        ok = 1'b0;
        for (int i = 0; i < 60 && !ok; i++) begin
            @(negedge mclk);
            ok = (s === v);
        end
    endtask
    task automatic req(int idx, int path, int beats, bit other);
        logic ok;
        @(posedge mclk);
        other_req <= other;
        periph_path <= dmast_path_t'(path);
        burst_beats <= 8'(beats);
        periph_req[idx] <= 1'b1;
        exp_q.push_back(exp_sp(path, beats));
        @(posedge mclk);
        other_req <= 1'b0;
        wait_for(pbusy, 1'b1, ok);
        `CHK(ok, 1'b1)
        `CHK(pstr, 3'(idx))
        @(posedge mclk);
        periph_req[idx] <= 1'b0;
    endtask
    task automatic item(int idx, int path, int beats, bit other);
        logic ok;
        int e;
        req(idx, path, beats, other);
        wait_for(done, 1'b1, ok);
        `CHK(ok, 1'b1)
        e = exp_q.pop_front();
        if (slow) begin
            `CHK(tsp >= 8'(e) && tsp <= 8'(e + 8), 1'b1)
        end else begin
            `CHK(tsp, 8'(e))
        end
        `CHK(tsm, other ? 8'h04 : 8'h03)
        `CHK(ts, 8'(tsp + (other ? 8'h04 : 8'h03)))
    endtask
    // ****************************************
    // main sequence
    // ****************************************
    initial begin
        logic ok;
        void'($urandom(32'h71782489));
        repeat (6) @(posedge mclk);
        rst_n <= 1'b1;
        repeat (2) @(posedge mclk);
        for (int p = 0; p < 3; p++) begin
            item($urandom % 8, p, 1, 1'b1);
            item($urandom % 8, p, 1 + $urandom % 4, 1'b0);
        end
        item(6, 0, 0, 1'b1);
        item(4, 0, 4, 1'b0);
        // two streams at once: lower index first, other taken back to back
        @(posedge mclk);
        periph_req <= 8'h24;
        wait_for(pbusy, 1'b1, ok);
        `CHK(pstr, 3'h2)
        @(posedge mclk);
        periph_req[2] <= 1'b0;
        n = 0;
        while (pstr !== 3'h5 && n < 40) begin
            @(negedge mclk);
            n++;
        end
        `CHK(pbusy, 1'b1)
        @(posedge mclk);
        periph_req <= 8'h00;
        repeat (20) @(posedge mclk);
        // memory-to-peripheral: prefetch before the request
        stream_m2p[3] <= 1'b1;
        wait_for(mbusy, 1'b1, ok);
        `CHK({ok, mwr, mstr}, {1'b1, 1'b0, 3'h3})
        repeat (10) @(posedge mclk);
        req(3, 2, 1, 1'b0);
        wait_for(pbusy, 1'b0, ok);
        `CHK(tsp, 8'(exp_q.pop_front()))
        repeat (10) @(posedge mclk);
        stream_m2p <= 8'h00;
        repeat (10) @(posedge mclk);
        // fifo mode: memory write only once the threshold is met
        fifo_mode <= 1'b1;
        req(1, 1, 1, 1'b1);
        void'(exp_q.pop_front());
        wait_for(pbusy, 1'b0, ok);
        n = 0;
        repeat (8) begin
            @(negedge mclk);
            n += mbusy;
        end
        `CHK(n, 0)
        item(1, 1, 1, 1'b1);
        fifo_mode <= 1'b0;
        repeat (10) @(posedge mclk);
        // contention and wait states from the far side
        slow <= 1'b1;
        for (int k = 0; k < 3; k++) item($urandom % 8, k, 2, 1'b0);
        slow <= 1'b0;
        repeat (10) @(posedge mclk);
        end_of_test();
    end
endmodule
`default_nettype wire
